// [include/nvc_pkg.sv]
// Constants and types for the data nonvolatile access controller
// Operation
// R01: 128-byte array, each byte read and programmed
// R02: Write in EE00h-EFFCh programs accumulator, step four
// R03: CPU held waiting until programming finishes
// R04: Peripherals keep running during the stall
// R05: Interrupts stay pending through stall, serviced after
// R06: Read in array range returns the addressed byte
// R07: E2h sets write enable, other values clear
// R08: Bit 5 reports enable; programming only when set
// R09: Software clears enable right after each write
// R10: Watchdog select 00 off, else time-out escape
// R11: Time-out flag bit 6, cleared while enable clear
// R12: Scratch RAM FF00h-FFFFh, external moves only
// R13: Locked array write changes nothing, no stall
package nvc_pkg;
	localparam logic [15:0] ARR_BASE = 16'hEE00;
	localparam logic [15:0] ARR_LAST = 16'hEFFC;
	localparam logic [15:0] SCRATCH_BASE = 16'hFF00;
	localparam logic [7:0] SFR_UNLOCK = 8'hC9;
	localparam logic [7:0] SFR_MISC2 = 8'hF7;
	localparam logic [7:0] UNLOCK_KEY = 8'hE2;
	localparam logic [7:0] MISC2_RESET = 8'h06;
	localparam int ENABLE_BIT = 5;
	localparam int TIMEOUT_BIT = 6;
	localparam int WDSEL_LSB = 1;
	localparam int WDSEL_MSB = 2;
	localparam logic [1:0] WD_OFF = 2'h0;
	localparam logic [1:0] WD_SHORT = 2'h1;
	localparam logic [1:0] WD_MID = 2'h2;
	localparam logic [1:0] WD_LONG = 2'h3;
	// Clock period in picoseconds (250 MHz)
	localparam longint CLK_PS = 4000;
	// Times in nanoseconds
	localparam longint PROG_NS = 2000000;
	localparam longint READ_NS = 300;
	localparam longint WD_SHORT_NS = 800000;
	localparam longint WD_MID_NS = 3100000;
	localparam longint WD_LONG_NS = 6200000;
	// Least times round up
	localparam longint PROG_CYC = (PROG_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam longint READ_CYC = (READ_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam longint WD_SHORT_CYC = (WD_SHORT_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam longint WD_MID_CYC = (WD_MID_NS * 1000 + CLK_PS - 1) / CLK_PS;
	localparam longint WD_LONG_CYC = (WD_LONG_NS * 1000 + CLK_PS - 1) / CLK_PS;
	typedef enum logic [1:0] {NVC_IDLE, NVC_READ, NVC_PROG} nvc_state_t;
endpackage

// [hdl/nvc_access_ctrl.sv]
// Data nonvolatile array access controller with unlock and write watchdog
module nvc_access_ctrl #(
	parameter int ARR_BYTES = 128,
	parameter int SCRATCH_BYTES = 256,
	parameter int PROG_CYCLES = int'(nvc_pkg::PROG_CYC),
	parameter int WD_SHORT_CYCLES = int'(nvc_pkg::WD_SHORT_CYC),
	parameter int WD_MID_CYCLES = int'(nvc_pkg::WD_MID_CYC),
	parameter int WD_LONG_CYCLES = int'(nvc_pkg::WD_LONG_CYC),
	parameter int READ_CYCLES = int'(nvc_pkg::READ_CYC),
	// Width of the cycle counters; must hold the longest watchdog span
	parameter int CW = 24
) (
	input wire logic core_clk,
	input wire logic rst,
	// External-move request from the core, same clock
	input wire logic xReq,
	input wire logic xWrite,
	input wire logic [15:0] xAddr,
	input wire logic [7:0] xWdata,
	output logic [7:0] xRdata,
	output logic xDone,
	output logic cpuWait,
	// Register-space access from the core, same clock
	input wire logic sfrWe,
	input wire logic sfrRe,
	input wire logic [7:0] sfrAddr,
	input wire logic [7:0] sfrWdata,
	output logic [7:0] sfrRdata,
	// Programming cell reports busy forever when stuck
	input wire logic cellStuck
);
	localparam int AW = $clog2(ARR_BYTES);
	localparam int XW = $clog2(SCRATCH_BYTES);
	// Cycles from an array read request to its done pulse
	localparam int READ_SPAN = READ_CYCLES + 1;

	// Storage arrays
	logic [7:0] arrMem [ARR_BYTES]; // [R01]
	logic [7:0] scratchMem [SCRATCH_BYTES]; // [R12]
	// Control registers
	logic enable_reg;
	logic timeout_reg;
	logic [7:0] misc2_reg;
	nvc_pkg::nvc_state_t state_reg;
	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] wdCnt_reg;
	logic [AW-1:0] progAddr_reg; // Array index latched when an array read or unlocked array write is taken
	logic [7:0] progData_reg;
	logic [7:0] xRdata_reg;
	logic xDone_reg;
	logic cpuWait_reg;
	logic [7:0] sfrRdata_reg;

	// Address decodes
	logic inArr;
	logic inScratch;
	logic [AW-1:0] arrIdx;
	logic [XW-1:0] xIdx;
	logic [1:0] wdSel;
	logic [CW-1:0] wdLimit;
	logic progFinish;
	logic wdFire;

	assign inArr = xAddr >= nvc_pkg::ARR_BASE && xAddr <= nvc_pkg::ARR_LAST
		&& xAddr[1:0] == 2'h0; // [R02]
	assign inScratch = xAddr >= nvc_pkg::SCRATCH_BASE; // [R12]
	assign arrIdx = AW'((xAddr - nvc_pkg::ARR_BASE) >> 2); // [R02]
	assign xIdx = xAddr[XW-1:0];
	assign wdSel = misc2_reg[nvc_pkg::WDSEL_MSB:nvc_pkg::WDSEL_LSB];

	// Watchdog limit from select field
	always_comb begin
		case (wdSel)
			nvc_pkg::WD_SHORT: wdLimit = CW'(WD_SHORT_CYCLES); // [R10]
			nvc_pkg::WD_MID: wdLimit = CW'(WD_MID_CYCLES); // [R10]
			nvc_pkg::WD_LONG: wdLimit = CW'(WD_LONG_CYCLES); // [R10]
			default: wdLimit = '0;
		endcase
	end

	assign progFinish = state_reg == nvc_pkg::NVC_PROG && !cellStuck
		&& cnt_reg >= CW'(PROG_CYCLES - 1);
	assign wdFire = state_reg == nvc_pkg::NVC_PROG && wdSel != nvc_pkg::WD_OFF
		&& wdCnt_reg >= wdLimit - CW'(1);

	// Sequencer for reads and programming
	always_ff @(posedge core_clk) begin
		if (rst) begin
			state_reg <= nvc_pkg::NVC_IDLE;
			cnt_reg <= '0;
			wdCnt_reg <= '0;
			xDone_reg <= 1'b0;
			cpuWait_reg <= 1'b0;
			progAddr_reg <= '0;
			progData_reg <= 8'h00;
			xRdata_reg <= 8'h00;
		end else begin
			xDone_reg <= 1'b0;
			case (state_reg)
				nvc_pkg::NVC_IDLE: begin
					cnt_reg <= '0;
					wdCnt_reg <= '0;
					if (xReq && inArr && xWrite && enable_reg) begin
						// Stall the core only; nothing else is gated [R03] [R04]
						state_reg <= nvc_pkg::NVC_PROG;
						cpuWait_reg <= 1'b1;
						progAddr_reg <= arrIdx;
						progData_reg <= xWdata;
					end else if (xReq && inArr && !xWrite) begin
						state_reg <= nvc_pkg::NVC_READ;
						cpuWait_reg <= 1'b1;
						// The core lets the address go, so keep the index
						progAddr_reg <= arrIdx;
					end else if (xReq) begin
						// Locked array write and RAM accesses end at once [R13]
						xDone_reg <= 1'b1;
						xRdata_reg <= inScratch && !xWrite ? scratchMem[xIdx] : 8'h00; // [R12]
					end
				end
				nvc_pkg::NVC_READ: begin
					cnt_reg <= cnt_reg + CW'(1);
					if (cnt_reg >= CW'(READ_CYCLES - 1)) begin
						xRdata_reg <= arrMem[progAddr_reg]; // [R06]
						xDone_reg <= 1'b1;
						cpuWait_reg <= 1'b0;
						state_reg <= nvc_pkg::NVC_IDLE;
					end
				end
				nvc_pkg::NVC_PROG: begin
					cnt_reg <= cnt_reg + CW'(1);
					wdCnt_reg <= wdCnt_reg + CW'(1);
					if (progFinish || wdFire) begin
						// Release the core; pending interrupts are then taken [R05]
						xDone_reg <= 1'b1;
						cpuWait_reg <= 1'b0; // [R03] [R10]
						state_reg <= nvc_pkg::NVC_IDLE;
					end
				end
				default: state_reg <= nvc_pkg::NVC_IDLE;
			endcase
		end
	end

	// Array cells take the byte at the end of a good programming pass
	always_ff @(posedge core_clk) begin
		if (progFinish && !wdFire) begin
			arrMem[progAddr_reg] <= progData_reg; // [R02] [R01]
		end
	end

	// Scratch RAM writes
	always_ff @(posedge core_clk) begin
		if (state_reg == nvc_pkg::NVC_IDLE && xReq && xWrite && inScratch) begin
			scratchMem[xIdx] <= xWdata; // [R12]
		end
	end

	// Unlock register: key sets, anything else clears
	always_ff @(posedge core_clk) begin
		if (rst) begin
			enable_reg <= 1'b0;
		end else if (sfrWe && sfrAddr == nvc_pkg::SFR_UNLOCK) begin
			enable_reg <= sfrWdata == nvc_pkg::UNLOCK_KEY; // [R07] [R09]
		end
	end

	// Time-out flag: set on watchdog escape, held clear while locked
	always_ff @(posedge core_clk) begin
		if (rst) begin
			timeout_reg <= 1'b0;
		end else if (wdFire) begin
			timeout_reg <= 1'b1; // [R11]
		end else if (!enable_reg) begin
			timeout_reg <= 1'b0; // [R11]
		end
	end

	// Misc control register with watchdog select
	always_ff @(posedge core_clk) begin
		if (rst) begin
			misc2_reg <= nvc_pkg::MISC2_RESET;
		end else if (sfrWe && sfrAddr == nvc_pkg::SFR_MISC2) begin
			misc2_reg <= sfrWdata;
		end
	end

	// Register read port
	always_ff @(posedge core_clk) begin
		if (rst) begin
			sfrRdata_reg <= 8'h00;
		end else if (sfrRe) begin
			case (sfrAddr)
				nvc_pkg::SFR_UNLOCK: begin
					sfrRdata_reg <= 8'h00;
					sfrRdata_reg[nvc_pkg::ENABLE_BIT] <= enable_reg; // [R08]
					sfrRdata_reg[nvc_pkg::TIMEOUT_BIT] <= timeout_reg; // [R11]
				end
				nvc_pkg::SFR_MISC2: sfrRdata_reg <= misc2_reg;
				default: sfrRdata_reg <= 8'h00;
			endcase
		end
	end

	assign xRdata = xRdata_reg;
	assign xDone = xDone_reg;
	assign cpuWait = cpuWait_reg;
	assign sfrRdata = sfrRdata_reg;

	// Helper counter for the checks: length of the current stall
	logic [CW-1:0] stallLen_reg;

	// Counts stalled cycles, restarts whenever the core runs
	always_ff @(posedge core_clk) begin
		if (rst) begin
			stallLen_reg <= '0;
		end else if (cpuWait_reg) begin
			stallLen_reg <= stallLen_reg + CW'(1);
		end else begin
			stallLen_reg <= '0;
		end
	end

	// Checks

	// Locked array write ends at once and never stalls
	prog_needs_key_a: assert property (@(posedge core_clk) disable iff (rst) // [R13]
		(state_reg == nvc_pkg::NVC_IDLE && xReq && inArr && xWrite && !enable_reg)
		|=> !cpuWait_reg && xDone_reg) else $error("locked write stalled");

	// Unlocked array write stalls the core
	prog_stall_a: assert property (@(posedge core_clk) disable iff (rst) // [R03]
		(state_reg == nvc_pkg::NVC_IDLE && xReq && inArr && xWrite && enable_reg)
		|=> cpuWait_reg) else $error("write did not stall");

	// Good programming pass lasts exactly the programming time
	prog_time_a: assert property (@(posedge core_clk) disable iff (rst) // [R03]
		progFinish |-> stallLen_reg == CW'(PROG_CYCLES - 1))
		else $error("programming time wrong");

	// Done pulse always frees the core
	done_releases_a: assert property (@(posedge core_clk) disable iff (rst) // [R03]
		xDone_reg |-> !cpuWait_reg) else $error("done while stalled");

	// Time-out flag drops while the key is off, unless it is being set
	timeout_clear_a: assert property (@(posedge core_clk) disable iff (rst) // [R11]
		!enable_reg && !wdFire |=> !timeout_reg) else $error("flag not cleared");

	// Watchdog escape sets the flag and frees the core
	timeout_set_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		wdFire |=> timeout_reg && !cpuWait_reg) else $error("escape failed");

	// An enabled watchdog never lets a write stall past its span
	stall_bound_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		(state_reg == nvc_pkg::NVC_PROG && wdSel != nvc_pkg::WD_OFF)
		|-> stallLen_reg < wdLimit) else $error("stall past watchdog span");

	// With the watchdog off a stuck write is never abandoned
	wd_off_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		(state_reg == nvc_pkg::NVC_PROG && wdSel == nvc_pkg::WD_OFF && cellStuck)
		|=> cpuWait_reg) else $error("watchdog off escaped");

	// Select field register takes what is written
	misc_write_a: assert property (@(posedge core_clk) disable iff (rst) // [R10]
		sfrWe && sfrAddr == nvc_pkg::SFR_MISC2
		|=> misc2_reg == $past(sfrWdata)) else $error("select write lost");

	// Key value sets the enable flag, any other value clears it
	key_sets_a: assert property (@(posedge core_clk) disable iff (rst) // [R07]
		sfrWe && sfrAddr == nvc_pkg::SFR_UNLOCK
		|=> enable_reg == ($past(sfrWdata) == nvc_pkg::UNLOCK_KEY))
		else $error("unlock wrong");

	// Array read answers after the fixed access time
	read_done_a: assert property (@(posedge core_clk) disable iff (rst) // [R06]
		(state_reg == nvc_pkg::NVC_IDLE && xReq && inArr && !xWrite)
		|-> ##READ_SPAN xDone_reg) else $error("read not done");

	// Unmapped reads give zero
	unmapped_zero_a: assert property (@(posedge core_clk) disable iff (rst) // [R06]
		(state_reg == nvc_pkg::NVC_IDLE && xReq && !xWrite && !inArr && !inScratch)
		|=> xRdata_reg == 8'h00) else $error("unmapped read not zero");

	// Scratch RAM moves end in one cycle without a stall
	scratch_fast_a: assert property (@(posedge core_clk) disable iff (rst) // [R12]
		(state_reg == nvc_pkg::NVC_IDLE && xReq && inScratch)
		|=> xDone_reg && !cpuWait_reg) else $error("scratch move slow");

	// Enable bit read back
	bit_report_a: assert property (@(posedge core_clk) disable iff (rst) // [R08]
		sfrRe && sfrAddr == nvc_pkg::SFR_UNLOCK
		|=> sfrRdata_reg[nvc_pkg::ENABLE_BIT] == $past(enable_reg))
		else $error("enable bit wrong");

	// Time-out bit read back
	timeout_report_a: assert property (@(posedge core_clk) disable iff (rst) // [R11]
		sfrRe && sfrAddr == nvc_pkg::SFR_UNLOCK
		|=> sfrRdata_reg[nvc_pkg::TIMEOUT_BIT] == $past(timeout_reg))
		else $error("time-out bit wrong");

	// Reset frees the core and drops both flags
	reset_clear_a: assert property (@(posedge core_clk) // [R07]
		rst |=> !cpuWait_reg && !xDone_reg && !enable_reg && !timeout_reg)
		else $error("reset left state");

	// Main scenarios
	cov_prog_c: cover property (@(posedge core_clk) progFinish);
	cov_wd_c: cover property (@(posedge core_clk) wdFire);
	cov_read_c: cover property (@(posedge core_clk)
		state_reg == nvc_pkg::NVC_READ ##1 xDone_reg);
	cov_lock_c: cover property (@(posedge core_clk)
		state_reg == nvc_pkg::NVC_IDLE && xReq && inArr && xWrite && !enable_reg);
	cov_scratch_c: cover property (@(posedge core_clk)
		state_reg == nvc_pkg::NVC_IDLE && xReq && inScratch && !xWrite);
endmodule // nvc_access_ctrl

// [sim/nvc_cpu_model.sv]
// Core-side model that issues external data moves one at a time
module nvc_cpu_model (
	input wire logic core_clk,
	output logic xReq,
	output logic xWrite,
	output logic [15:0] xAddr,
	output logic [7:0] xWdata,
	input wire logic [7:0] xRdata,
	input wire logic xDone
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle outputs at time zero
	initial begin
		xReq = 1'b0;
		xWrite = 1'b0;
		xAddr = 16'h0000;
		xWdata = 8'h00;
	end
	// One move: request for one cycle, then count cycles to the done pulse
	task automatic xmove(input logic w, input logic [15:0] a, input logic [7:0] d,
			output logic [7:0] q, output int n);
		@(negedge core_clk);
		xReq = 1'b1;
		xWrite = w;
		xAddr = a;
		xWdata = d;
		@(negedge core_clk);
		xReq = 1'b0;
		// Released lines show the inverse so a stale value is never trusted
		xAddr = ~a;
		xWdata = ~d;
		n = 1;
		while (xDone !== 1'b1 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
		q = xRdata;
	endtask
endmodule // nvc_cpu_model

// [sim/tb_top.sv]
// Self-checking bench for the nonvolatile access controller
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin fails++; \
	$display("mismatch at %0t got %h expected %h", $time, g, e); end end
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int PROG = 20;
	localparam int RD = 75;
	typedef struct {logic w; logic [15:0] a; logic [7:0] d; logic [7:0] q; int n;} nvc_row_t;
	logic core_clk = 1'b0, rst = 1'b1, sfrWe = 1'b0, sfrRe = 1'b0, cellStuck = 1'b0;
	logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, xRdata, q;
	logic xReq, xWrite, xDone, cpuWait;
	logic [15:0] xAddr;
	logic [7:0] xWdata;
	int fails = 0, comparisons = 0, n;
	int wdc[4] = '{0, 10, 30, 60};
	// Plain moves with their expected data and latency
	nvc_row_t rows[10] = '{
		'{1, 16'hFF00, 8'hA5, 8'h00, 1}, '{0, 16'hFF00, 8'h00, 8'hA5, 1},
		'{1, 16'hFFFF, 8'h3C, 8'h00, 1}, '{0, 16'hFFFF, 8'h00, 8'h3C, 1},
		'{1, 16'hEE00, 8'h5A, 8'h00, PROG + 1}, '{0, 16'hEE00, 8'h00, 8'h5A, RD + 1},
		'{1, 16'hEFFC, 8'hC3, 8'h00, PROG + 1}, '{0, 16'hEFFC, 8'h00, 8'hC3, RD + 1},
		'{0, 16'hEE01, 8'h00, 8'h00, 1}, '{0, 16'h1234, 8'h00, 8'h00, 1}};
	// 250 MHz clock
	always #2 core_clk = ~core_clk;
	nvc_access_ctrl #(.PROG_CYCLES(PROG), .WD_SHORT_CYCLES(10), .WD_MID_CYCLES(30),
			.WD_LONG_CYCLES(60), .READ_CYCLES(RD)) i_dut (.core_clk(core_clk), .rst(rst),
		.xReq(xReq), .xWrite(xWrite), .xAddr(xAddr), .xWdata(xWdata), .xRdata(xRdata),
		.xDone(xDone), .cpuWait(cpuWait), .sfrWe(sfrWe), .sfrRe(sfrRe), .sfrAddr(sfrAddr),
		.sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .cellStuck(cellStuck));
	nvc_cpu_model i_cpu (.core_clk(core_clk), .xReq(xReq), .xWrite(xWrite), .xAddr(xAddr),
		.xWdata(xWdata), .xRdata(xRdata), .xDone(xDone));
	// Register write pulse
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge core_clk);
		sfrWe = 1'b1;
		sfrAddr = a;
		sfrWdata = d;
		@(negedge core_clk);
		sfrWe = 1'b0;
	endtask
	// Register read pulse, data valid the cycle after
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge core_clk);
		sfrRe = 1'b1;
		sfrAddr = a;
		@(negedge core_clk);
		sfrRe = 1'b0;
		d = sfrRdata;
	endtask
	// Counts and verdict
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, fails);
		if (fails == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	// Watchdog against a hang
	initial begin
		#40000;
		fails++;
		summarize();
	end
	// Main sequence
	initial begin
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		sfr_rd(8'hC9, q);
		`CHK(q[6:5], 2'b00)
		sfr_rd(8'hF7, q);
		`CHK(q, 8'h06)
		$display("test reset done");
		sfr_wr(8'hC9, 8'hE2);
		sfr_rd(8'hC9, q);
		`CHK(q[5], 1'b1)
		foreach (rows[i]) begin
			i_cpu.xmove(rows[i].w, rows[i].a, rows[i].d, q, n);
			`CHK(n, rows[i].n)
			if (!rows[i].w) `CHK(q, rows[i].q)
			// Software drops the key after each array write, then arms it again
			if (rows[i].w && rows[i].a < 16'hFF00) begin
				sfr_wr(8'hC9, 8'h00);
				sfr_wr(8'hC9, 8'hE2);
			end
		end
		$display("test rows done");
		i_cpu.xmove(1'b1, 16'hEE04, 8'h33, q, n);
		sfr_wr(8'hC9, 8'hE3);
		sfr_rd(8'hC9, q);
		`CHK(q[5], 1'b0)
		i_cpu.xmove(1'b1, 16'hEE04, 8'h11, q, n);
		`CHK(n, 1)
		i_cpu.xmove(1'b0, 16'hEE04, 8'h00, q, n);
		`CHK(q, 8'h33)
		$display("test lock done");
		cellStuck = 1'b1;
		for (int s = 1; s < 4; s++) begin
			sfr_wr(8'hF7, 8'(s << 1));
			sfr_wr(8'hC9, 8'hE2);
			i_cpu.xmove(1'b1, 16'hEE08, 8'h77, q, n);
			`CHK(n, wdc[s] + 1)
			sfr_rd(8'hC9, q);
			`CHK(q[6:5], 2'b11)
			sfr_wr(8'hC9, 8'h00);
			sfr_rd(8'hC9, q);
			`CHK(q[6:5], 2'b00)
		end
		$display("test watchdog done");
		// Stuck write with the watchdog off never ends; only reset frees the core
		sfr_wr(8'hF7, 8'h00);
		sfr_wr(8'hC9, 8'hE2);
		i_cpu.xmove(1'b1, 16'hEE0C, 8'h55, q, n);
		`CHK(n, 1000)
		`CHK(cpuWait, 1'b1)
		rst = 1'b1;
		repeat (12) @(negedge core_clk);
		rst = 1'b0;
		`CHK(cpuWait, 1'b0)
		sfr_rd(8'hF7, q);
		`CHK(q, 8'h06)
		sfr_rd(8'hC9, q);
		`CHK(q[6:5], 2'b00)
		$display("test stall reset done");
		summarize();
	end
endmodule // tb_top
